// ### logic/nvws_params.svh
// Register offsets, codes, field positions and timing constants
`ifndef NVWS_PARAMS_SVH
`define NVWS_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define NVWS_OFS_AREA      8'h00
`define NVWS_OFS_DATA      8'h04
`define NVWS_OFS_ADDR_LO   8'h08
`define NVWS_OFS_ADDR_HI   8'h0C
`define NVWS_OFS_KEY       8'h10
`define NVWS_OFS_CTL       8'h14
`define NVWS_OFS_STATUS    8'h18
`define NVWS_OFS_CFG       8'h1C
// ----------------------------------------
// Area codes, command codes, hold codes
// ----------------------------------------
`define NVWS_AREA_CODE     8'h00
`define NVWS_AREA_INFO     8'h01
`define NVWS_AREA_EEPROM   8'h02
`define NVWS_CMD_WRITE     2'b10
`define NVWS_HOLD_4MS      2'b00
`define NVWS_HOLD_2MS      2'b01
`define NVWS_HOLD_1MS      2'b10
// ----------------------------------------
// Field positions and address-high width
// ----------------------------------------
`define NVWS_CTL_CMD_LO    0
`define NVWS_CTL_HOLD_LO   2
`define NVWS_ADDR_HI_W     5
// ----------------------------------------
// Timing: hold times in microseconds, clock in MHz; bus response codes
// ----------------------------------------
`define NVWS_CLK_MHZ       50
`define NVWS_HOLD_4MS_US   4000
`define NVWS_HOLD_2MS_US   2000
`define NVWS_HOLD_1MS_US   1000
`define NVWS_RESP_OKAY     2'b00
`define NVWS_RESP_SLVERR   2'b10
`endif

// ### logic/nvws_pkg.sv
// Types shared by the write sequencer
package nvws_pkg;
	// Sequencer states, Gray along idle->hold->done
	typedef enum logic [1:0] {
		NVWS_IDLE = 2'b00,
		NVWS_HOLD = 2'b01,
		NVWS_DONE = 2'b11
	} nvws_state_t;
	// One programming request to the array
	typedef struct packed {
		logic [1:0]  area;
		logic [12:0] addr;
		logic [7:0]  data;
	} nvws_prog_t;
endpackage : nvws_pkg

// ### logic/nvws_seq.sv
// Nonvolatile write sequencer with an AXI4-Lite register slave
`timescale 1ns/1ns
`include "nvws_params.svh"
module nvws_seq
	import nvws_pkg::*;
#(
	parameter int unsigned CLK_MHZ  = `NVWS_CLK_MHZ,
	parameter int unsigned HOLD4_CY = `NVWS_HOLD_4MS_US * CLK_MHZ,
	parameter int unsigned HOLD2_CY = `NVWS_HOLD_2MS_US * CLK_MHZ,
	parameter int unsigned HOLD1_CY = `NVWS_HOLD_1MS_US * CLK_MHZ
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              code_write_lock,
	output logic                   cpu_hold,
	output nvws_prog_t             prog_req,
	output logic                   prog_strobe,
	input  wire logic              prog_done,
	output logic [1:0]             read_area,
	output logic [12:0]            read_base
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]   area_r, area_nxt;          // Area select
	logic [7:0]   wdat_r, wdat_nxt;          // Write data
	logic [7:0]   alo_r, alo_nxt;            // Address low
	logic [4:0]   ahi_r, ahi_nxt;            // Address high
	logic [3:0]   ctl_r, ctl_nxt;            // Hold and command
	logic [7:0]   key_r, key_nxt;            // Window count left
	logic         arm_r, arm_nxt;            // Programming armed
	logic         ign_r, ign_nxt;            // Sticky: write refused
	logic [31:0]  hcnt_r, hcnt_nxt;          // Hold cycles left
	nvws_state_t  st_r, st_nxt;              // Sequencer state
	logic         hold_r, hold_nxt;          // CPU stall
	nvws_prog_t   preq_r, preq_nxt;          // Programming request
	logic         pstb_r, pstb_nxt;          // Start pulse
	// Bus channel state
	logic         awr_r, awr_nxt;
	logic         wr_r, wr_nxt;
	logic         bv_r, bv_nxt;
	logic         arr_r, arr_nxt;
	logic         rv_r, rv_nxt;
	logic [31:0]  rd_r, rd_nxt;
	logic [1:0]   rrsp_r, rrsp_nxt;
	logic [1:0]   brsp_r, brsp_nxt;
	logic [7:0]   awa_r, awa_nxt;            // Latched write address
	logic         awh_r, awh_nxt;            // Address held
	logic [31:0]  wd_r, wd_nxt;              // Latched write data
	logic         wh_r, wh_nxt, ws_r, ws_nxt; // Data held; its low-byte strobe rides along
	// Combinational helpers
	logic         do_wr;
	logic         cmd_ok;
	logic         wr_allowed;
	logic [31:0]  hold_len;

	// ----------------------------------------
	// Hold length from code
	// ----------------------------------------
	// hold code decode
	always_comb
	begin
		unique case (wd_r[`NVWS_CTL_HOLD_LO +: 2])
			`NVWS_HOLD_4MS: hold_len = HOLD4_CY;
			`NVWS_HOLD_2MS: hold_len = HOLD2_CY;
			default:        hold_len = HOLD1_CY; // Reserved treated as shortest
		endcase
	end

	// ----------------------------------------
	// Bus slave and register file
	// ----------------------------------------
	// Write fires once address and data are both held
	assign do_wr = awh_r && wh_r && !bv_r;
	assign cmd_ok = (wd_r[`NVWS_CTL_CMD_LO +: 2] == `NVWS_CMD_WRITE);
	// code lock and info read only
	assign wr_allowed = arm_r && (st_r == NVWS_IDLE)
		&& ((area_r == `NVWS_AREA_EEPROM)
		|| ((area_r == `NVWS_AREA_CODE) && !code_write_lock));

	// Next state of bus, registers and sequencer
	always_comb
	begin
		awr_nxt  = awr_r;
		wr_nxt   = wr_r;
		bv_nxt   = bv_r;
		arr_nxt  = arr_r;
		rv_nxt   = rv_r;
		rd_nxt   = rd_r;
		rrsp_nxt = rrsp_r;
		brsp_nxt = brsp_r;
		awa_nxt  = awa_r;
		awh_nxt  = awh_r;
		wd_nxt   = wd_r;
		wh_nxt   = wh_r;
		area_nxt = area_r;
		wdat_nxt = wdat_r;
		alo_nxt  = alo_r;
		ahi_nxt  = ahi_r;
		ctl_nxt  = ctl_r;
		key_nxt  = key_r;
		arm_nxt  = arm_r;
		ign_nxt  = ign_r;
		hcnt_nxt = hcnt_r;
		st_nxt   = st_r;
		hold_nxt = hold_r;
		preq_nxt = preq_r;
		pstb_nxt = 1'b0;
		// Address and data taken in either order
		awr_nxt = !awh_r && !(s_axi_awvalid && awr_r);
		wr_nxt  = !wh_r && !(s_axi_wvalid && wr_r);
		ws_nxt  = (s_axi_wvalid && wr_r) ? s_axi_wstrb[0] : ws_r;
		if (s_axi_awvalid && awr_r)
		begin
			awa_nxt = s_axi_awaddr;
			awh_nxt = 1'b1;
		end
		if (s_axi_wvalid && wr_r)
		begin
			wd_nxt = s_axi_wdata;
			wh_nxt = 1'b1;
		end
		if (arm_r)
		begin
			if (key_r <= 8'h01)
			begin
				arm_nxt = 1'b0;
				key_nxt = 8'h00;
			end
			else
				key_nxt = key_r - 8'h01;
		end
		if (do_wr)
		begin
			awh_nxt  = 1'b0;
			wh_nxt   = 1'b0;
			bv_nxt   = 1'b1;
			brsp_nxt = `NVWS_RESP_OKAY;
			if (ws_r)
			begin
				unique case (awa_r)
					`NVWS_OFS_AREA:    area_nxt = wd_r[7:0];
					`NVWS_OFS_DATA:    wdat_nxt = wd_r[7:0];
					`NVWS_OFS_ADDR_LO: alo_nxt  = wd_r[7:0];
					`NVWS_OFS_ADDR_HI: ahi_nxt  = wd_r[`NVWS_ADDR_HI_W-1:0];
					`NVWS_OFS_KEY:
					begin
						key_nxt = wd_r[7:0];
						arm_nxt = (wd_r[7:0] != 8'h00);
					end
					`NVWS_OFS_CTL:
					begin
						ctl_nxt = wd_r[3:0];
						if (cmd_ok && wr_allowed)
						begin
							hold_nxt = 1'b1;
							pstb_nxt = 1'b1;
							st_nxt   = NVWS_HOLD;
							hcnt_nxt = hold_len;
							preq_nxt = '{area: area_r[1:0], addr: {ahi_r, alo_r},
								data: wdat_r};
							arm_nxt  = 1'b0;
							key_nxt  = 8'h00;
						end
						else if (cmd_ok)
							ign_nxt = 1'b1; // Refused write recorded
					end
					`NVWS_OFS_STATUS:  ign_nxt = ign_r && !wd_r[1];
					default:           brsp_nxt = `NVWS_RESP_SLVERR;
				endcase
			end
		end
		if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
		// Read channel, one outstanding
		arr_nxt = !rv_r && !(s_axi_arvalid && arr_r);
		if (s_axi_arvalid && arr_r)
		begin
			rv_nxt   = 1'b1;
			rrsp_nxt = `NVWS_RESP_OKAY;
			unique case (s_axi_araddr)
				`NVWS_OFS_AREA:    rd_nxt = {24'h00_0000, area_r};
				`NVWS_OFS_DATA:    rd_nxt = {24'h00_0000, wdat_r};
				`NVWS_OFS_ADDR_LO: rd_nxt = {24'h00_0000, alo_r};
				`NVWS_OFS_ADDR_HI: rd_nxt = {27'h000_0000, ahi_r};
				`NVWS_OFS_KEY:     rd_nxt = {24'h00_0000, key_r};
				`NVWS_OFS_CTL:     rd_nxt = {28'h000_0000, ctl_r};
				`NVWS_OFS_STATUS:  rd_nxt = {29'h0000_0000, arm_r, ign_r, hold_r};
				`NVWS_OFS_CFG:     rd_nxt = {31'h0000_0000, code_write_lock};
				default:
				begin
					rd_nxt   = 32'h0000_0000;
					rrsp_nxt = `NVWS_RESP_SLVERR;
				end
			endcase
		end
		if (rv_r && s_axi_rready)
			rv_nxt = 1'b0;
		unique case (st_r)
			NVWS_IDLE: ;
			NVWS_HOLD:
			begin
				if (hcnt_r > 32'h0000_0001)
					hcnt_nxt = hcnt_r - 32'h0000_0001;
				else
					st_nxt = NVWS_DONE;
			end
			NVWS_DONE:
			begin
				// Wait for array, then resume at next instruction
				if (prog_done)
				begin
					hold_nxt = 1'b0;
					st_nxt   = NVWS_IDLE;
				end
			end
			default:   st_nxt = NVWS_IDLE;
		endcase
	end

	// Register everything
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_r <= 1'b0; wr_r <= 1'b0; bv_r <= 1'b0; arr_r <= 1'b0; rv_r <= 1'b0;
			rd_r <= 32'h0000_0000; rrsp_r <= 2'b00; brsp_r <= 2'b00;
			awa_r <= 8'h00; awh_r <= 1'b0; wd_r <= 32'h0000_0000; wh_r <= 1'b0; ws_r <= 1'b0;
			area_r <= 8'h00; wdat_r <= 8'h00; alo_r <= 8'h00; ahi_r <= 5'h00;
			ctl_r <= 4'h0; key_r <= 8'h00; arm_r <= 1'b0; ign_r <= 1'b0;
			hcnt_r <= 32'h0000_0000; st_r <= NVWS_IDLE; hold_r <= 1'b0;
			preq_r <= '0; pstb_r <= 1'b0;
		end
		else
		begin
			awr_r <= awr_nxt; wr_r <= wr_nxt; bv_r <= bv_nxt; arr_r <= arr_nxt;
			rv_r <= rv_nxt; rd_r <= rd_nxt; rrsp_r <= rrsp_nxt; brsp_r <= brsp_nxt;
			awa_r <= awa_nxt; awh_r <= awh_nxt; wd_r <= wd_nxt; wh_r <= wh_nxt; ws_r <= ws_nxt;
			area_r <= area_nxt; wdat_r <= wdat_nxt; alo_r <= alo_nxt; ahi_r <= ahi_nxt;
			ctl_r <= ctl_nxt; key_r <= key_nxt; arm_r <= arm_nxt; ign_r <= ign_nxt;
			hcnt_r <= hcnt_nxt; st_r <= st_nxt; hold_r <= hold_nxt;
			preq_r <= preq_nxt; pstb_r <= pstb_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = awr_r;
	assign s_axi_wready  = wr_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = brsp_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rdata   = rd_r;
	assign s_axi_rresp   = rrsp_r;
	assign cpu_hold      = hold_r;
	assign prog_req      = preq_r;
	assign prog_strobe   = pstb_r;
	assign read_area     = area_r[1:0];
	assign read_base     = {ahi_r, alo_r};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence cmd_taken_s;
		do_wr && ws_r && awa_r == `NVWS_OFS_CTL && cmd_ok && wr_allowed;
	endsequence
	start_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_taken_s |=> cpu_hold && prog_strobe) else $error("hold not started");
	bad_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> $past(wd_r[1:0]) == `NVWS_CMD_WRITE) else $error("bad cmd");
	key_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> !arm_r) else $error("key not cleared");
	lock_area_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> prog_req.area == 2'b10 || !$past(code_write_lock))
		else $error("locked write");
	info_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> prog_req.area != 2'b01) else $error("info written");
	addr_form_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> prog_req.addr == {$past(ahi_r), $past(alo_r)})
		else $error("address wrong");
	data_use_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_strobe |-> prog_req.data == $past(wdat_r)) else $error("data wrong");
	release_cpu_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == NVWS_DONE && prog_done |=> !cpu_hold) else $error("no release");
	disarm_exp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		arm_r && key_r == 8'h01 && !do_wr |=> !arm_r) else $error("window stuck");
	area_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && ws_r && awa_r == `NVWS_OFS_AREA |=> read_area == $past(wd_r[1:0]))
		else $error("area route");
endmodule : nvws_seq

// ### tb/tb_nvws_seq.sv
// Self-checking bench for the nonvolatile write sequencer
`timescale 1ns/1ns
`include "nvws_params.svh"
module tb_nvws_seq
	import nvws_pkg::*;
();
	// ----------------------------------------
	// Signals and counters
	// ----------------------------------------
	localparam int H4 = 20;            // Shortened hold counts for a quick run
	localparam int H2 = 10;
	localparam int H1 = 5;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs, bs, read_area;
	logic        code_write_lock, cpu_hold, prog_strobe, prog_done;
	logic [12:0] read_base;
	nvws_prog_t  prog_req, req;        // Request latched at the strobe
	int          bad_count, check_count, strobes, hold_len;

	nvws_seq #(.HOLD4_CY(H4), .HOLD2_CY(H2), .HOLD1_CY(H1)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.code_write_lock(code_write_lock), .cpu_hold(cpu_hold), .prog_req(prog_req),
		.prog_strobe(prog_strobe), .prog_done(prog_done),
		.read_area(read_area), .read_base(read_base));

	// Free-running system clock
	initial
	begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end

	// Strobe counter; hold length counted after the strobe edge
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strobes  <= 0;
			hold_len <= 0;
		end
		else if (prog_strobe === 1'b1)
		begin
			strobes  <= strobes + 1;
			req      <= prog_req;
			hold_len <= 0;
		end
		else if (cpu_hold === 1'b1)
			hold_len <= hold_len + 1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	// A hung handshake ends the run as a failure
	task automatic limit(input int n);
		if (n >= 100)
		begin
			bad_count++;
			final_report();
		end
	endtask : limit

	// Address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_d, w_d;
		n = 0;
		aw_d = 0;
		w_d = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_d && w_d) && n < 100)
		begin
			@(posedge aclk);
			n++;
			if (!aw_d && awready === 1'b1)
			begin
				aw_d = 1;
				awvalid <= 0;
			end
			if (!w_d && wready === 1'b1)
			begin
				w_d = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1 && n < 100)
		begin
			@(posedge aclk);
			n++;
		end
		// Response taken at the bvalid edge; bready stays up between writes
		bs = bresp;
		limit(n);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 0;
		end
		while (rvalid !== 1'b1 && n < 100);
		rd = rdata;
		rs = rresp;
		limit(n);
	endtask : axi_rd

	// Issue a control word and compare the number of starts
	task automatic launch(input logic [7:0] c, input int exp);
		int n0;
		n0 = strobes;
		axi_wr(`NVWS_OFS_CTL, {24'h0, c});
		repeat (4) @(posedge aclk);
		check(strobes - n0, exp);
	endtask : launch

	task automatic wait_idle();
		int n;
		n = 0;
		while (cpu_hold !== 1'b0 && n < 100)
		begin
			@(posedge aclk);
			n++;
		end
		limit(n);
	endtask : wait_idle

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin : main
		logic [1:0] codes [3];
		int holds [3];
		logic [7:0] bad_cmd [3];
		codes = '{2'b00, 2'b01, 2'b10};
		holds = '{H4, H2, H1};
		bad_cmd = '{8'h08, 8'h09, 8'h0B};
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready, code_write_lock} = '0;
		{bad_count, check_count} = '0;
		prog_done = 1;
		aresetn = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axi_rd(`NVWS_OFS_AREA);
		check(rd, 32'h0000_0000);
		// EEPROM write, completion held back to show the stall
		axi_wr(`NVWS_OFS_AREA, 32'h0000_0002);
		check(bs, `NVWS_RESP_OKAY);
		axi_wr(`NVWS_OFS_DATA, 32'h0000_005A);
		axi_wr(`NVWS_OFS_ADDR_HI, 32'h0000_0000);
		axi_wr(`NVWS_OFS_ADDR_LO, 32'h0000_0033);
		check(read_area, 2'd2);
		check(read_base, 13'h0033);
		prog_done <= 0;
		axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
		launch(8'h0A, 1);
		check(req, {2'd2, 13'h0033, 8'h5A});
		repeat (H1 + 10) @(posedge aclk);
		check(cpu_hold, 1'b1);
		prog_done <= 1;
		repeat (3) @(posedge aclk);
		check(cpu_hold, 1'b0);
		// A second command without a fresh unlock is refused
		launch(8'h0A, 0);
		axi_rd(`NVWS_OFS_STATUS);
		check(rd[1], 1'b1);
		axi_wr(`NVWS_OFS_STATUS, 32'h0000_0002);
		axi_rd(`NVWS_OFS_STATUS);
		check(rd[1], 1'b0);
		// Each hold code gives its own stall length
		for (int i = 0; i < 3; i++)
		begin
			axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
			launch({4'h0, codes[i], 2'b10}, 1);
			wait_idle();
			check(hold_len >= holds[i] - 1 && hold_len <= holds[i] + 2, 1);
		end
		// Reserved command codes never start
		for (int i = 0; i < 3; i++)
		begin
			axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
			launch(bad_cmd[i], 0);
		end
		// Short window left to run out
		axi_wr(`NVWS_OFS_KEY, 32'h0000_0004);
		repeat (10) @(posedge aclk);
		launch(8'h0A, 0);
		// Locked code area, then unlocked code write
		axi_wr(`NVWS_OFS_AREA, 32'h0000_0000);
		axi_wr(`NVWS_OFS_ADDR_HI, 32'h0000_0015);
		axi_wr(`NVWS_OFS_ADDR_LO, 32'h0000_00A7);
		code_write_lock <= 1;
		axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
		launch(8'h0A, 0);
		axi_rd(`NVWS_OFS_CFG);
		check(rd[0], 1'b1);
		check(read_area, 2'd0);
		code_write_lock <= 0;
		axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
		launch(8'h0A, 1);
		check(req, {2'd0, 13'h15A7, 8'h5A});
		wait_idle();
		// Information area reads only
		axi_wr(`NVWS_OFS_AREA, 32'h0000_0001);
		check(read_area, 2'd1);
		axi_wr(`NVWS_OFS_KEY, 32'h0000_00F0);
		launch(8'h0A, 0);
		// Back to the code area once the special area work is over
		axi_wr(`NVWS_OFS_AREA, 32'h0000_0000);
		check(read_area, 2'd0);
		// Unmapped offset answers with an error
		axi_rd(8'h40);
		check(rs, `NVWS_RESP_SLVERR);
		axi_wr(8'h40, 32'h0000_0000);
		check(bs, `NVWS_RESP_SLVERR);
		final_report();
	end : main
endmodule : tb_nvws_seq
